/* File: pkg/fra_map.svh */
/*
  Register offsets, field positions, reset values and sizes of the flash read accelerator.
  Assumes inclusion by the package, the design module, the array model and the bench.
*/
`ifndef FRA_MAP_SVH
`define FRA_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FRA_OFS_MODE 8'h00
`define FRA_OFS_READY 8'h04
`define FRA_OFS_ISTAT 8'h08
`define FRA_OFS_IMASK 8'h0c
`define FRA_OFS_LOCK 8'h10

// ----------------------------------------
// Mode register fields and reset value
// ----------------------------------------
`define FRA_MODE_WS_LSB 8
`define FRA_MODE_WS_W 4
`define FRA_MODE_SOD_BIT 16
`define FRA_MODE_AWS_BIT 24
`define FRA_MODE_RESET 32'h0000_0000

// ----------------------------------------
// Flash geometry
// ----------------------------------------
`define FRA_FLASH_AW 19
`define FRA_PAGE_WORDS 64
`define FRA_PAGE_IW 6
`define FRA_LOCK_BITS 16
`define FRA_WIN_AW 20

`endif

/* File: pkg/fra_pkg.sv */
/*
  Types of the flash read accelerator.
  Assumes the map header sits beside it on the include path.
*/
`include "fra_map.svh"

package fra_pkg;

  typedef enum logic [1:0] {
    FRA_ST_IDLE = 2'b01,
    FRA_ST_WAIT = 2'b10
  } fra_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0] size;
    logic code;
  } fra_req_t;

  typedef struct packed {
    logic valid;
    logic [`FRA_FLASH_AW-4:0] tag;
    logic [127:0] line;
  } fra_buf_t;

endpackage

/* File: design/fra_flash_read_accel.sv */
/*
  Flash read accelerator: wait states, 128/64-bit array access, two code buffers, one data
  buffer, page write buffer, lock bits and the ready-rise interrupt.
  Assumes a master that waits for bus_ready_out before its next flash request, and an array
  that returns the line on array_line_in while array_rd_out is high.
*/
// Design decisions made here: the plain strobed port and the address map.
// Function
// - serve byte, halfword and word reads
// - flash image repeats through whole window
// - wait states programmable, zero means two cycles
// - first sequential access ws+2, then one cycle
// - 128-bit array access after reset
// - width bit selects 64-bit array access
// - two code buffers as wide as access
// - disable bit switches off code buffers
// - code hits survive gaps between fetches
// - data read loads whole aligned line
// - disable bit also kills data buffer
// - data hits survive gaps between reads
// - always clocked, never gated
// - interrupt only on ready flag rising
// - page write buffer across 1 MByte window
// - sixteen lock bits guard lock regions
`timescale 1ns/100ps
`include "fra_map.svh"

module fra_flash_read_accel
  import fra_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic bus_rd_in,
  input wire logic bus_wr_in,
  input wire fra_req_t bus_req_in,
  input wire logic [31:0] bus_wdata_in,
  output logic bus_ready_out,
  output logic [31:0] bus_rdata_out,
  output logic array_rd_out,
  output logic array_wide_out,
  output logic [`FRA_FLASH_AW-4:0] array_addr_out,
  input wire logic [127:0] array_line_in,
  input wire logic [`FRA_PAGE_IW-1:0] wbuf_idx_in,
  output logic [31:0] wbuf_data_out,
  input wire logic ready_flag_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic [`FRA_LOCK_BITS-1:0] lock_bits_out,
  output logic irq_out
);

  // ----------------------------------------
  // Decoding functions
  // ----------------------------------------
  function automatic logic buf_hit(input fra_buf_t b, input logic [`FRA_FLASH_AW-4:0] t,
                                   input logic narrow);
    buf_hit = b.valid && (b.tag[`FRA_FLASH_AW-4:1] == t[`FRA_FLASH_AW-4:1])
              && (!narrow || (b.tag[0] == t[0]));
  endfunction

  function automatic logic [31:0] pick(input logic [127:0] line, input logic [3:0] off,
                                       input logic [1:0] size, input logic narrow);
    logic [1:0] widx;
    logic [31:0] word;
    logic [31:0] sh;
    widx = narrow ? {1'b0, off[2]} : off[3:2];
    word = line[32*widx +: 32];
    sh = word >> {off[1:0], 3'b000};
    unique case (size)
      2'b00: pick = {24'h00_0000, sh[7:0]};
      2'b01: pick = {16'h0000, sh[15:0]};
      default: pick = word;
    endcase
  endfunction

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  fra_state_t state_r, state_nxt;
  fra_buf_t buf_r [3];
  fra_buf_t buf_nxt [3];
  logic victim_r, victim_nxt;
  fra_req_t req_r, req_nxt;
  logic [`FRA_MODE_WS_W-1:0] wcnt_r, wcnt_nxt;
  logic bus_ready_nxt;
  logic [31:0] bus_rdata_nxt;
  logic array_rd_nxt;
  logic [`FRA_FLASH_AW-4:0] array_addr_nxt;
  logic [31:0] flash_mode_reg_r, flash_mode_reg_nxt;
  logic [`FRA_LOCK_BITS-1:0] lock_nxt;
  logic [1:0] ready_sync_r;
  logic ready_d_r, ready_d_nxt;
  logic istat_r, istat_nxt, imask_r, imask_nxt, irq_nxt;
  logic [31:0] reg_rdata_nxt;
  logic [31:0] wbuf_mem [`FRA_PAGE_WORDS];
  logic [31:0] wbuf_data_nxt;

  logic [`FRA_MODE_WS_W-1:0] read_wait_states;
  logic sequential_opt_disable, access_width_select;
  logic [`FRA_FLASH_AW-4:0] req_tag;
  logic hit_c0, hit_c1, hit_d, hit, ready_rise, mode_wr;

  assign read_wait_states = flash_mode_reg_r[`FRA_MODE_WS_LSB +: `FRA_MODE_WS_W];
  assign sequential_opt_disable = flash_mode_reg_r[`FRA_MODE_SOD_BIT];
  assign access_width_select = flash_mode_reg_r[`FRA_MODE_AWS_BIT];
  assign req_tag = bus_req_in.addr[`FRA_FLASH_AW-1:3];
  assign hit_c0 = bus_req_in.code && buf_hit(buf_r[0], req_tag, access_width_select);
  assign hit_c1 = bus_req_in.code && buf_hit(buf_r[1], req_tag, access_width_select);
  assign hit_d = !bus_req_in.code && buf_hit(buf_r[2], req_tag, access_width_select);
  assign hit = !sequential_opt_disable && (hit_c0 || hit_c1 || hit_d);
  assign ready_rise = ready_sync_r[1] && !ready_d_r;
  assign mode_wr = reg_wr_in && (reg_addr_in == `FRA_OFS_MODE);

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    buf_nxt = buf_r;
    victim_nxt = victim_r;
    req_nxt = req_r;
    wcnt_nxt = wcnt_r;
    bus_ready_nxt = 1'b0;
    bus_rdata_nxt = bus_rdata_out;
    array_rd_nxt = array_rd_out;
    array_addr_nxt = array_addr_out;
    unique case (state_r)
      FRA_ST_IDLE:
      begin
        if (bus_wr_in)
        begin
          bus_ready_nxt = 1'b1;
        end
        else if (bus_rd_in && hit)
        begin
          bus_ready_nxt = 1'b1;
          bus_rdata_nxt = pick(hit_c0 ? buf_r[0].line : hit_c1 ? buf_r[1].line : buf_r[2].line,
                               bus_req_in.addr[3:0], bus_req_in.size,
                               access_width_select);
        end
        else if (bus_rd_in)
        begin
          state_nxt = FRA_ST_WAIT;
          req_nxt = bus_req_in;
          wcnt_nxt = read_wait_states;
          array_rd_nxt = 1'b1;
          array_addr_nxt = access_width_select ? req_tag : {req_tag[`FRA_FLASH_AW-4:1], 1'b0};
        end
      end
      FRA_ST_WAIT:
      begin
        if (wcnt_r == '0)
        begin
          state_nxt = FRA_ST_IDLE;
          array_rd_nxt = 1'b0;
          bus_ready_nxt = 1'b1;
          bus_rdata_nxt = pick(array_line_in, req_r.addr[3:0], req_r.size,
                               access_width_select);
          if (req_r.code)
          begin
            buf_nxt[victim_r] = '{1'b1, array_addr_out, array_line_in};
            victim_nxt = !victim_r;
          end
          else
          begin
            buf_nxt[2] = '{1'b1, array_addr_out, array_line_in};
          end
        end
        else
        begin
          wcnt_nxt = wcnt_r - 1'b1;
        end
      end
    endcase
    if (mode_wr)
    begin
      for (int i = 0; i < 3; i++)
      begin
        buf_nxt[i].valid = 1'b0;
      end
    end
  end

  // The controller has no clock gate; every flop runs on every edge.
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_r <= FRA_ST_IDLE;
      for (int i = 0; i < 3; i++)
      begin
        buf_r[i] <= '0;
      end
      victim_r <= 1'b0;
      req_r <= '0;
      wcnt_r <= '0;
      bus_ready_out <= 1'b0;
      bus_rdata_out <= '0;
      array_rd_out <= 1'b0;
      array_addr_out <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      buf_r <= buf_nxt;
      victim_r <= victim_nxt;
      req_r <= req_nxt;
      wcnt_r <= wcnt_nxt;
      bus_ready_out <= bus_ready_nxt;
      bus_rdata_out <= bus_rdata_nxt;
      array_rd_out <= array_rd_nxt;
      array_addr_out <= array_addr_nxt;
    end
  end

  // ----------------------------------------
  // Page write buffer
  // ----------------------------------------
  assign wbuf_data_nxt = wbuf_mem[wbuf_idx_in];

  always_ff @(posedge clock_in)
  begin
    if (bus_wr_in && state_r == FRA_ST_IDLE)
    begin
      wbuf_mem[bus_req_in.addr[`FRA_PAGE_IW+1:2]] <= bus_wdata_in;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wbuf_data_out <= '0;
    end
    else
    begin
      wbuf_data_out <= wbuf_data_nxt;
    end
  end

  // ----------------------------------------
  // Registers and interrupt
  // ----------------------------------------
  always_comb
  begin
    flash_mode_reg_nxt = mode_wr ? reg_wdata_in : flash_mode_reg_r;
    lock_nxt = lock_bits_out;
    imask_nxt = imask_r;
    istat_nxt = istat_r;
    ready_d_nxt = ready_sync_r[1];
    reg_rdata_nxt = '0;
    if (reg_wr_in && reg_addr_in == `FRA_OFS_LOCK)
    begin
      lock_nxt = reg_wdata_in[`FRA_LOCK_BITS-1:0];
    end
    if (reg_wr_in && reg_addr_in == `FRA_OFS_IMASK)
    begin
      imask_nxt = reg_wdata_in[0];
    end
    if (reg_wr_in && reg_addr_in == `FRA_OFS_ISTAT && reg_wdata_in[0])
    begin
      istat_nxt = 1'b0;
    end
    if (ready_rise)
    begin
      istat_nxt = 1'b1;
    end
    irq_nxt = istat_r && imask_r;
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        `FRA_OFS_MODE: reg_rdata_nxt = flash_mode_reg_r;
        `FRA_OFS_READY: reg_rdata_nxt = {31'h0000_0000, ready_d_r};
        `FRA_OFS_ISTAT: reg_rdata_nxt = {31'h0000_0000, istat_r};
        `FRA_OFS_IMASK: reg_rdata_nxt = {31'h0000_0000, imask_r};
        `FRA_OFS_LOCK: reg_rdata_nxt = {16'h0000, lock_bits_out};
        default: reg_rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      flash_mode_reg_r <= `FRA_MODE_RESET;
      lock_bits_out <= '0;
      imask_r <= 1'b0;
      istat_r <= 1'b0;
      ready_sync_r <= 2'b00;
      ready_d_r <= 1'b0;
      irq_out <= 1'b0;
      reg_rdata_out <= '0;
      array_wide_out <= 1'b1;
    end
    else
    begin
      flash_mode_reg_r <= flash_mode_reg_nxt;
      lock_bits_out <= lock_nxt;
      imask_r <= imask_nxt;
      istat_r <= istat_nxt;
      ready_sync_r <= {ready_sync_r[0], ready_flag_in};
      ready_d_r <= ready_d_nxt;
      irq_out <= irq_nxt;
      reg_rdata_out <= reg_rdata_nxt;
      array_wide_out <= !flash_mode_reg_nxt[`FRA_MODE_AWS_BIT];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  logic [4:0] lat_r;
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      lat_r <= '0;
    end
    else
    begin
      lat_r <= (state_r == FRA_ST_IDLE) ? 5'h01 : lat_r + 5'h01;
    end
  end

  a_hit_one_cycle: assert property (bus_rd_in && hit && state_r == FRA_ST_IDLE
      |=> bus_ready_out)
    else $error("buffer hit not answered next cycle");
  a_miss_latency: assert property (state_r == FRA_ST_WAIT && state_nxt == FRA_ST_IDLE
      |-> lat_r == 5'(read_wait_states) + 5'h01)
    else $error("miss latency wrong");
  a_miss_fetches: assert property (bus_rd_in && !hit && state_r == FRA_ST_IDLE
      |=> array_rd_out && state_r == FRA_ST_WAIT)
    else $error("miss did not fetch");
  a_disable_fetch: assert property (sequential_opt_disable && bus_rd_in
      && state_r == FRA_ST_IDLE |=> array_rd_out && !bus_ready_out)
    else $error("read served from buffer while buffers disabled");
  a_irq_on_rise: assert property ($rose(istat_r) |-> $past(ready_rise))
    else $error("interrupt status set without ready rise");
  a_irq_follows: assert property (istat_r && imask_r |=> irq_out)
    else $error("unmasked status not signalled");
  a_wrap_addr: assert property (bus_rd_in && !hit && state_r == FRA_ST_IDLE
      |=> array_addr_out[`FRA_FLASH_AW-4:1] == $past(bus_req_in.addr[`FRA_FLASH_AW-1:4]))
    else $error("array address not wrapped");
  a_width_sel: assert property (array_rd_out
      |-> array_wide_out == !access_width_select)
    else $error("array width mismatch");
  a_lock_write: assert property (reg_wr_in && reg_addr_in == `FRA_OFS_LOCK
      |=> lock_bits_out == $past(reg_wdata_in[`FRA_LOCK_BITS-1:0]))
    else $error("lock bits not written");
  a_data_fill: assert property (state_r == FRA_ST_WAIT && wcnt_r == '0
      && !req_r.code && !mode_wr
      |=> buf_r[2].valid && buf_r[2].line == $past(array_line_in))
    else $error("data buffer not filled");

  c_code_hit: cover property (bus_rd_in && hit_c0 && !sequential_opt_disable);
  c_data_hit: cover property (bus_rd_in && hit_d && !sequential_opt_disable);
  c_miss_ws3: cover property (state_r == FRA_ST_WAIT && read_wait_states == 4'h3);
  c_irq: cover property ($rose(irq_out));

endmodule

/* File: verif/fra_array_model.sv */
/*
  Flash array model for the read accelerator bench: word n of the image holds {15'h61d2, n}.
  Assumes the accelerator holds array_addr_in steady while array_rd_in is high.
*/
`timescale 1ns/100ps
`include "fra_map.svh"

module fra_array_model
  import fra_pkg::*;
(
  input wire logic clock_in,
  input wire logic array_rd_in,
  input wire logic [`FRA_FLASH_AW-4:0] array_addr_in,
  output logic [127:0] array_line_out
);
  // ----------------------------------------
  // Line output
  // ----------------------------------------
  logic [127:0] junk_r;

  initial junk_r = {4{32'h9e37_79b9}};

  // The lines change every cycle outside a fetch, so stale data cannot pass.
  always @(posedge clock_in)
  begin
    junk_r <= ~junk_r;
  end

  always_comb
  begin
    array_line_out = junk_r;
    if (array_rd_in)
    begin
      for (int i = 0; i < 4; i++)
      begin
        array_line_out[32*i+:32] = {15'h61d2, 17'({array_addr_in, 1'b0} + 17'(i))};
      end
    end
  end
endmodule

/* File: verif/test_flash_read_accelerator.sv */
/*
  Self-checking bench of the flash read accelerator.
  Assumes fra_pkg and the array model are compiled first.
*/
`timescale 1ns/100ps
`include "fra_map.svh"

module test_flash_read_accelerator
  import fra_pkg::*;
;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic bus_rd = 1'b0;
  logic bus_wr = 1'b0;
  fra_req_t req = '0;
  logic [31:0] wdata = '0;
  logic ready;
  logic [31:0] rdata;
  logic array_rd;
  logic array_wide;
  logic [`FRA_FLASH_AW-4:0] array_addr;
  logic [127:0] array_line;
  logic [5:0] wbuf_idx = '0;
  logic [31:0] wbuf_data;
  logic ready_flag = 1'b0;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [15:0] lock_bits;
  logic irq;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] d;
  int n;

  always #12.5 clock_in = ~clock_in;

  fra_flash_read_accel fra_flash_read_accel_i (.clock_in(clock_in), .rst_in(rst_in),
    .bus_rd_in(bus_rd), .bus_wr_in(bus_wr), .bus_req_in(req), .bus_wdata_in(wdata),
    .bus_ready_out(ready), .bus_rdata_out(rdata), .array_rd_out(array_rd),
    .array_wide_out(array_wide), .array_addr_out(array_addr), .array_line_in(array_line),
    .wbuf_idx_in(wbuf_idx), .wbuf_data_out(wbuf_data), .ready_flag_in(ready_flag),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .lock_bits_out(lock_bits), .irq_out(irq));

  fra_array_model fra_array_model_i (.clock_in(clock_in), .array_rd_in(array_rd),
    .array_addr_in(array_addr), .array_line_out(array_line));

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_in);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock_in);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock_in);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock_in);
    reg_rd <= 1'b0;
    @(posedge clock_in);
    v = reg_rdata;
  endtask

  task automatic set_mode(input logic [3:0] ws, input logic sod, input logic aws);
    reg_write(8'h00, {7'h0, aws, 7'h0, sod, 4'h0, ws, 8'h0});
  endtask

  // One request, then count cycles to the answer; n is 1 for a hit.
  task automatic flash_op(input logic wr, input logic [31:0] a, input logic [1:0] sz,
                          input logic code);
    @(posedge clock_in);
    bus_rd <= ~wr;
    bus_wr <= wr;
    req <= '{addr: a, size: sz, code: code};
    @(posedge clock_in);
    bus_rd <= 1'b0;
    bus_wr <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clock_in);
      n++;
    end while (ready !== 1'b1 && n < 20);
    d = rdata;
  endtask

  task automatic read_chk(input logic [31:0] a, input logic [1:0] sz, input logic code,
                          input int lat);
    logic [31:0] w;
    w = {15'h61d2, a[18:2]};
    if (sz == 2'd0)
      w = (w >> (8 * a[1:0])) & 32'h0000_00ff;
    else if (sz == 2'd1)
      w = (w >> (16 * a[1])) & 32'h0000_ffff;
    flash_op(1'b0, a, sz, code);
    chk("read data", w, d);
    chk("read latency", 32'(lat), 32'(n));
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    reg_read(8'h00, d);
    chk("mode reset", 32'h0, d);
    chk("wide after reset", 32'h1, {31'h0, array_wide});
    reg_read(8'h40, d);
    chk("unmapped read", 32'h0, d);
    chk("irq after reset", 32'h0, {31'h0, irq});
    $display("reset test done");
  endtask

  task automatic t_data();
    set_mode(4'h0, 1'b0, 1'b0);
    read_chk(32'h0000_0100, 2'd2, 1'b0, 2);
    read_chk(32'h0000_0105, 2'd0, 1'b0, 1);
    read_chk(32'h0000_010e, 2'd1, 1'b0, 1);
    read_chk(32'h0008_0108, 2'd2, 1'b0, 1);
    read_chk(32'h0000_0110, 2'd2, 1'b0, 2);
    $display("data buffer test done");
  endtask

  task automatic t_code();
    set_mode(4'h3, 1'b0, 1'b0);
    read_chk(32'h0000_0200, 2'd2, 1'b1, 5);
    read_chk(32'h0000_0204, 2'd2, 1'b1, 1);
    read_chk(32'h0000_020b, 2'd0, 1'b1, 1);
    read_chk(32'h0000_0210, 2'd2, 1'b1, 5);
    read_chk(32'h0000_020c, 2'd2, 1'b1, 1);
    $display("code buffer test done");
  endtask

  task automatic t_narrow();
    set_mode(4'h1, 1'b0, 1'b1);
    read_chk(32'h0000_0300, 2'd2, 1'b0, 3);
    chk("wide in 64-bit mode", 32'h0, {31'h0, array_wide});
    read_chk(32'h0000_0304, 2'd2, 1'b0, 1);
    read_chk(32'h0000_0308, 2'd2, 1'b0, 3);
    read_chk(32'h0000_0400, 2'd2, 1'b1, 3);
    read_chk(32'h0000_0408, 2'd2, 1'b1, 3);
    read_chk(32'h0000_0404, 2'd2, 1'b1, 1);
    $display("64-bit test done");
  endtask

  task automatic t_disable();
    set_mode(4'h1, 1'b1, 1'b0);
    reg_read(8'h00, d);
    chk("mode readback", 32'h0001_0100, d);
    read_chk(32'h0000_0500, 2'd2, 1'b0, 3);
    read_chk(32'h0000_0504, 2'd2, 1'b0, 3);
    read_chk(32'h0000_0600, 2'd2, 1'b1, 3);
    read_chk(32'h0000_0604, 2'd2, 1'b1, 3);
    $display("disable test done");
  endtask

  task automatic t_wbuf_lock();
    wdata <= 32'h5e11_0b7a;
    flash_op(1'b1, 32'h000f_ff14, 2'd2, 1'b0);
    chk("write answer", 32'h1, {31'h0, ready});
    chk("write latency", 32'h1, 32'(n));
    wbuf_idx <= 6'h05;
    @(posedge clock_in);
    @(posedge clock_in);
    chk("page buffer word", 32'h5e11_0b7a, wbuf_data);
    reg_write(8'h10, 32'h0000_a5c3);
    @(posedge clock_in);
    chk("lock bits", 32'h0000_a5c3, {16'h0, lock_bits});
    reg_read(8'h10, d);
    chk("lock readback", 32'h0000_a5c3, d);
    $display("write buffer and lock test done");
  endtask

  task automatic t_irq();
    reg_write(8'h0c, 32'h1);
    ready_flag <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock_in);
      n++;
    end while (irq !== 1'b1 && n < 8);
    chk("irq on ready rise", 32'h1, {31'h0, irq});
    reg_read(8'h04, d);
    chk("ready flag read", 32'h1, d);
    reg_write(8'h08, 32'h1);
    reg_read(8'h08, d);
    chk("status cleared", 32'h0, d);
    chk("irq cleared", 32'h0, {31'h0, irq});
    ready_flag <= 1'b0;
    repeat (8) @(posedge clock_in);
    reg_read(8'h08, d);
    chk("no event on fall", 32'h0, d);
    reg_write(8'h0c, 32'h0);
    ready_flag <= 1'b1;
    repeat (8) @(posedge clock_in);
    chk("masked irq", 32'h0, {31'h0, irq});
    reg_read(8'h08, d);
    chk("masked status", 32'h1, d);
    $display("interrupt test done");
  endtask

  // ----------------------------------------
  // Sequence and verdict
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    t_reset();
    t_data();
    t_code();
    t_narrow();
    t_disable();
    t_wbuf_lock();
    t_irq();
    end_of_test();
  end
endmodule
